// ### core/tpio_pin_stage.sv
`timescale 1ns/1ns
`default_nettype none
module tpio_pin_stage
	import tpio_pkg::*;
#(
	parameter int W          = 8,
	parameter bit OPEN_DRAIN = 1'b0
) (
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	tpio_stage_if.stage       st_if,
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] pin_o,
	output logic      [W-1:0] pin_oe
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] level;
		logic [W-1:0] out;
		logic [W-1:0] oe;
	} tpio_stage_s;

	tpio_stage_s q_reg;
	tpio_stage_s q_next;

	// ------------------------------------------------------------
	// synchroniser and driver selection
	// ------------------------------------------------------------
	always_comb begin
		q_next = q_reg;
		q_next.meta = pin_i;
		q_next.level = q_reg.meta;
		// per bit: push-pull, sink-only, or released
		for (int i = 0; i < W; i++) begin
			if (st_if.drive_sel[i]) begin
				q_next.oe[i] = 1'b1;
				q_next.out[i] = st_if.value[i];
			end else if (OPEN_DRAIN) begin
				q_next.oe[i] = ~st_if.value[i];
				q_next.out[i] = 1'b0;
			end else begin
				q_next.oe[i] = 1'b0;
				q_next.out[i] = st_if.value[i];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q_reg <= '{meta: RST_PIN, level: RST_PIN, out: RST_PIN, oe: RST_PIN};
		end else begin
			q_reg <= q_next;
		end
	end

	assign st_if.level = q_reg.level;
	assign pin_o = q_reg.out;
	assign pin_oe = q_reg.oe;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_live_level;
		@(posedge clk_sys) disable iff (!rst_n)
		// start only once reset is sampled released, so the synchroniser holds real pins
		rst_n |-> ##2 st_if.level == $past(pin_i, 2);
	endproperty
	a_live_level: assert property (p_live_level) else $error("level not live pin");

	property p_drive_sel;
		@(posedge clk_sys) disable iff (!rst_n)
		1'b1 |=> pin_oe == ($past(st_if.drive_sel) | (OPEN_DRAIN ? ~$past(st_if.value) : '0));
	endproperty
	a_drive_sel: assert property (p_drive_sel) else $error("driver enable wrong");

	property p_od_sink;
		@(posedge clk_sys) disable iff (!rst_n)
		1'b1 |=> !OPEN_DRAIN || ((pin_o & ~$past(st_if.drive_sel)) == '0);
	endproperty
	a_od_sink: assert property (p_od_sink) else $error("open drain drives high");

endmodule
`default_nettype wire

// ### core/tpio_top.sv
`timescale 1ns/1ns
`default_nettype none
// Contract
// - output pins keep values in latches; pin reads return live levels
// - a port read samples the pin levels in the first bus state
// - a port write changes the output latch in the second bus state
// - reset sets port A latch to ones and driver type to zeros
// - port A type bit zero gives open drain, one gives push-pull
// - port A has separate latch read and pin level read paths
// - port B direction bit zero is input, one enables output driver
// - reset clears port B direction bits and output latch to zero
// - port B data read gives latch for outputs, pin level for inputs
// - bit manipulation on port B writes pin levels back into input bit latches; on port A it works on the latch
module tpio_top
	import tpio_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [7:0]  pa_pin_i,
	output logic      [7:0]  pa_pin_o,
	output logic      [7:0]  pa_pin_oe,
	input  wire logic [7:0]  pa_periph_out_i,
	output logic      [7:0]  pa_level_o,
	input  wire logic [7:0]  pb_pin_i,
	output logic      [7:0]  pb_pin_o,
	output logic      [7:0]  pb_pin_oe,
	input  wire logic [7:0]  pb_periph_out_i,
	output logic      [7:0]  pb_level_o
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		tpio_bus_e   st;
		logic [7:0]  a_latch;
		logic [7:0]  a_type;
		logic [7:0]  b_latch;
		logic [7:0]  b_dir;
		logic [7:0]  snap_b;
		logic [31:0] rdata;
	} tpio_state_s;

	tpio_state_s q_reg;
	tpio_state_s q_next;

	logic [7:0] adr;

	tpio_stage_if #(.W(PORT_W)) ifa ();
	tpio_stage_if #(.W(PORT_W)) ifb ();

	// word-aligned register address
	assign adr = {wb_adr_i[7:2], 2'b00};

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// port B data view: latch where driven, pin level where input
	function automatic logic [7:0] port_b_view(
		input logic [7:0] latch,
		input logic [7:0] dir,
		input logic [7:0] pins
	);
		port_b_view = (latch & dir) | (pins & ~dir);
	endfunction

	// apply one bit operation to a byte
	function automatic logic [7:0] apply_bitop(
		input logic [7:0]  base,
		input logic [2:0]  idx,
		input tpio_bitop_e op
	);
		logic [7:0] mask;
		mask = 8'h01 << idx;
		unique case (op)
			BITOP_SET: apply_bitop = base | mask;
			BITOP_CLR: apply_bitop = base & ~mask;
			BITOP_TGL: apply_bitop = base ^ mask;
			BITOP_NOP: apply_bitop = base;
		endcase
	endfunction

	// ------------------------------------------------------------
	// bus cycle and register file
	// ------------------------------------------------------------
	always_comb begin
		logic        wr;
		logic [7:0]  base;
		logic [7:0]  rd;
		wr = wb_we_i && wb_sel_i[0];
		base = 8'h00;
		rd = 8'h00;
		q_next = q_reg;
		unique case (q_reg.st)
			ST_IDLE: begin
				if (wb_cyc_i && wb_stb_i) begin
					q_next.st = ST_S1;
				end
			end
			ST_S1: begin
				// pins are sampled here, first state of the cycle
				unique case (adr)
					OFS_A_LATCH: rd = q_reg.a_latch;
					OFS_A_TYPE:  rd = q_reg.a_type;
					OFS_A_PIN:   rd = ifa.level;
					OFS_B_LATCH: rd = port_b_view(q_reg.b_latch, q_reg.b_dir, ifb.level);
					OFS_B_DIR:   rd = q_reg.b_dir;
					default:     rd = 8'h00;  // unmapped and write-only read zero
				endcase
				q_next.rdata = {24'h000000, rd};
				q_next.snap_b = ifb.level;
				q_next.st = ST_S2;
			end
			ST_S2: begin
				// written values take effect here, second state
				if (wr) begin
					unique case (adr)
						OFS_A_LATCH: q_next.a_latch = wb_dat_i[7:0];
						OFS_A_TYPE:  q_next.a_type = wb_dat_i[7:0];
						OFS_B_LATCH: q_next.b_latch = wb_dat_i[7:0];
						OFS_B_DIR:   q_next.b_dir = wb_dat_i[7:0];
						OFS_BITOP: begin
							if (wb_dat_i[BITOP_PORT]) begin
								base = port_b_view(q_reg.b_latch, q_reg.b_dir, q_reg.snap_b);
								q_next.b_latch = apply_bitop(base,
									wb_dat_i[BITOP_IDX_LSB +: 3],
									tpio_bitop_e'(wb_dat_i[BITOP_OP_LSB +: 2]));
							end else begin
								base = q_reg.a_latch;
								q_next.a_latch = apply_bitop(base,
									wb_dat_i[BITOP_IDX_LSB +: 3],
									tpio_bitop_e'(wb_dat_i[BITOP_OP_LSB +: 2]));
							end
						end
						default: begin
						end
					endcase
				end
				q_next.st = ST_ACK;
			end
			ST_ACK: begin
				q_next.st = ST_IDLE;
			end
		endcase
	end

	// register the whole state
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q_reg.st <= ST_IDLE;
			q_reg.a_latch <= RST_A_LATCH;
			q_reg.a_type <= RST_A_TYPE;
			q_reg.b_latch <= RST_B_LATCH;
			q_reg.b_dir <= RST_B_DIR;
			q_reg.snap_b <= RST_PIN;
			q_reg.rdata <= 32'h00000000;
		end else begin
			q_reg <= q_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign wb_ack_o = (q_reg.st == ST_ACK);
	assign wb_dat_o = q_reg.rdata;
	assign pa_level_o = ifa.level;
	assign pb_level_o = ifb.level;

	// peripheral output only pulls a pin low while the latch is one
	assign ifa.value = q_reg.a_latch & pa_periph_out_i;
	assign ifa.drive_sel = q_reg.a_type;
	assign ifb.value = q_reg.b_latch & pb_periph_out_i;
	assign ifb.drive_sel = q_reg.b_dir;

	// ------------------------------------------------------------
	// pin stages
	// ------------------------------------------------------------
	// port A: selectable open drain
	tpio_pin_stage #(
		.W          (PORT_W),
		.OPEN_DRAIN (1'b1)
	) u_stage_a (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.st_if   (ifa),
		.pin_i   (pa_pin_i),
		.pin_o   (pa_pin_o),
		.pin_oe  (pa_pin_oe)
	);

	// port B: plain direction control
	tpio_pin_stage #(
		.W          (PORT_W),
		.OPEN_DRAIN (1'b0)
	) u_stage_b (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.st_if   (ifb),
		.pin_i   (pb_pin_i),
		.pin_o   (pb_pin_o),
		.pin_oe  (pb_pin_oe)
	);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	logic       s2_wr;
	logic       bitop_b;
	logic [7:0] bit_mask;

	// helper terms for the checks
	assign s2_wr = (q_reg.st == ST_S2) && wb_we_i && wb_sel_i[0];
	assign bitop_b = s2_wr && (adr == OFS_BITOP) && wb_dat_i[BITOP_PORT];
	assign bit_mask = 8'h01 << wb_dat_i[2:0];

	property p_reset_a;
		$rose(rst_n) |-> q_reg.a_latch == RST_A_LATCH && q_reg.a_type == RST_A_TYPE;
	endproperty
	a_reset_a: assert property (p_reset_a) else $error("port A reset values wrong");

	property p_reset_b;
		$rose(rst_n) |-> q_reg.b_latch == RST_B_LATCH && q_reg.b_dir == RST_B_DIR;
	endproperty
	a_reset_b: assert property (p_reset_b) else $error("port B reset values wrong");

	property p_pin_sample;
		(q_reg.st == ST_S1 && adr == OFS_A_PIN) |=> q_reg.rdata[7:0] == $past(ifa.level);
	endproperty
	a_pin_sample: assert property (p_pin_sample) else $error("pin read not sampled in S1");

	property p_latch_read;
		(q_reg.st == ST_S1 && adr == OFS_A_LATCH) |=> q_reg.rdata[7:0] == $past(q_reg.a_latch);
	endproperty
	a_latch_read: assert property (p_latch_read) else $error("latch read path wrong");

	property p_write_s2;
		(s2_wr && adr == OFS_A_LATCH) |=> q_reg.a_latch == $past(wb_dat_i[7:0]);
	endproperty
	a_write_s2: assert property (p_write_s2) else $error("latch write missed");

	property p_hold_latch;
		(q_reg.st != ST_S2) |=> $stable(q_reg.a_latch) && $stable(q_reg.b_latch);
	endproperty
	a_hold_latch: assert property (p_hold_latch) else $error("latch moved outside S2");

	property p_b_view;
		(q_reg.st == ST_S1 && adr == OFS_B_LATCH) |=> q_reg.rdata[7:0] ==
			(($past(q_reg.b_latch) & $past(q_reg.b_dir)) | ($past(ifb.level) & ~$past(q_reg.b_dir)));
	endproperty
	a_b_view: assert property (p_b_view) else $error("port B read mix wrong");

	property p_bitop_inputs;
		bitop_b |=> ((q_reg.b_latch ^ $past(q_reg.snap_b)) & ~$past(q_reg.b_dir)
			& ~$past(bit_mask)) == 8'h00;
	endproperty
	a_bitop_inputs: assert property (p_bitop_inputs) else $error("input bits not written back");

	property p_ack_timing;
		(q_reg.st == ST_IDLE && wb_cyc_i && wb_stb_i) |-> ##3 wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack_timing: assert property (p_ack_timing) else $error("ack not three cycles later");

	c_pin_read: cover property (q_reg.st == ST_S1 && adr == OFS_A_PIN);
	c_bitop_b: cover property (bitop_b && (q_reg.b_dir != 8'h00) && (q_reg.b_dir != 8'hFF));
	c_type_write: cover property (s2_wr && adr == OFS_A_TYPE && wb_dat_i[7:0] != 8'h00);

endmodule
`default_nettype wire

// ### dv/tpio_board_model.sv
`timescale 1ns/1ns
`default_nettype none
// board side of both ports
module tpio_board_model (
	input  wire logic [7:0] pa_pin_o,
	input  wire logic [7:0] pa_pin_oe,
	input  wire logic [7:0] pa_ext,
	output logic      [7:0] pa_pin,
	input  wire logic [7:0] pb_pin_o,
	input  wire logic [7:0] pb_pin_oe,
	input  wire logic [7:0] pb_ext,
	output logic      [7:0] pb_pin
);
	// driven bits show the driver, released bits the external source
	assign pa_pin = (pa_pin_oe & pa_pin_o) | (~pa_pin_oe & pa_ext);
	assign pb_pin = (pb_pin_oe & pb_pin_o) | (~pb_pin_oe & pb_ext);
endmodule
`default_nettype wire

// ### dv/two_port_parallel_io_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module two_port_parallel_io_tb_top
	import tpio_pkg::*;
;
	typedef struct packed {
		logic        we;
		logic [7:0]  adr;
		logic [31:0] dat;
		logic [7:0]  exp;
	} tpio_row_s;

	logic        clk_sys = 1'b0;
	logic        rst_n   = 1'b0;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i  = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic [7:0]  pa_pin, pa_pin_o, pa_pin_oe, pb_pin, pb_pin_o, pb_pin_oe;
	logic [7:0]  pa_ext = 8'h5A;
	logic [7:0]  pb_ext = 8'h3C;
	logic [7:0]  pa_periph = 8'hFF;
	logic [7:0]  pa_level;
	logic [7:0]  pb_level;
	logic [31:0] rd;
	int          n_mismatch = 0;
	int          comparisons = 0;
	int          cycles = 0;
	tpio_row_s   rows [9];

	// ------------------------------------------------------------
	// clock, timeout, instances
	// ------------------------------------------------------------
	always #5 clk_sys = ~clk_sys;

	// cut a hang short
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_mismatch = n_mismatch + 1;
			give_verdict();
		end
	end

	tpio_top dut (
		.clk_sys         (clk_sys),
		.rst_n           (rst_n),
		.wb_cyc_i        (wb_cyc_i),
		.wb_stb_i        (wb_stb_i),
		.wb_we_i         (wb_we_i),
		.wb_adr_i        (wb_adr_i),
		.wb_sel_i        (wb_sel_i),
		.wb_dat_i        (wb_dat_i),
		.wb_dat_o        (wb_dat_o),
		.wb_ack_o        (wb_ack_o),
		.pa_pin_i        (pa_pin),
		.pa_pin_o        (pa_pin_o),
		.pa_pin_oe       (pa_pin_oe),
		.pa_periph_out_i (pa_periph),
		.pa_level_o      (pa_level),
		.pb_pin_i        (pb_pin),
		.pb_pin_o        (pb_pin_o),
		.pb_pin_oe       (pb_pin_oe),
		.pb_periph_out_i (8'hFF),
		.pb_level_o      (pb_level)
	);

	tpio_board_model board (
		.pa_pin_o  (pa_pin_o),
		.pa_pin_oe (pa_pin_oe),
		.pa_ext    (pa_ext),
		.pa_pin    (pa_pin),
		.pb_pin_o  (pb_pin_o),
		.pb_pin_oe (pb_pin_oe),
		.pb_ext    (pb_ext),
		.pb_pin    (pb_pin)
	);

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	// one classic cycle, entered just after a rising edge
	task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat,
		output logic [31:0] q);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'h1;
		wb_dat_i <= dat;
		q = 32'h0000_0000;
		do begin
			@(posedge clk_sys);
			n = n + 1;
		end while (wb_ack_o !== 1'b1 && n < 50);
		// a missing answer counts as a mismatch
		if (wb_ack_o !== 1'b1) begin
			n_mismatch = n_mismatch + 1;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, wb_ack_o, 1'b1);
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons = comparisons + 1;
		if (got !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic give_verdict();
		$display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		// port A latch stays one while type bits go high; B latch before dir
		rows[0] = '{1'b1, OFS_A_TYPE,  32'h0000_000F, 8'h00};
		rows[1] = '{1'b0, OFS_A_TYPE,  32'h0000_0000, 8'h0F};
		rows[2] = '{1'b1, OFS_A_LATCH, 32'h0000_003C, 8'h00};
		rows[3] = '{1'b0, OFS_A_LATCH, 32'h0000_0000, 8'h3C};
		rows[4] = '{1'b0, OFS_A_PIN,   32'h0000_0000, 8'h1C};
		rows[5] = '{1'b1, OFS_B_LATCH, 32'h0000_00A5, 8'h00};
		rows[6] = '{1'b1, OFS_B_DIR,   32'h0000_00F0, 8'h00};
		rows[7] = '{1'b0, OFS_B_LATCH, 32'h0000_0000, 8'hAC};
		rows[8] = '{1'b0, OFS_B_DIR,   32'h0000_0000, 8'hF0};
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		// table of ordinary register and pin cases
		for (int i = 0; i < 9; i++) begin
			bus(rows[i].we, rows[i].adr, rows[i].dat, rd);
			if (!rows[i].we) check(rd, {24'h0, rows[i].exp});
		end
		check({pa_pin_oe, pa_pin_o}, 16'hCF0C);
		check({pb_pin_oe, pb_pin_o}, 16'hF0A5);
		// live level seen after the source changes
		pa_ext <= 8'hFF;
		repeat (3) @(posedge clk_sys);
		bus(1'b0, OFS_A_PIN, 32'h0, rd);
		check(rd, 32'h0000_003C);
		check({pa_level, pb_level}, 16'h3CAC);
		// peripheral low on bit 2 pulls the push-pull pin low
		pa_periph <= 8'hFB;
		repeat (2) @(posedge clk_sys);
		check({24'h0, pa_pin_o}, 32'h0000_0008);
		pa_periph <= 8'hFF;
		@(posedge clk_sys);
		// set bit 6 on mixed port B: input bits take the pin levels
		bus(1'b1, OFS_BITOP, 32'h0000_0106, rd);
		bus(1'b1, OFS_B_DIR, 32'h0000_00FF, rd);
		bus(1'b0, OFS_B_LATCH, 32'h0, rd);
		check(rd, 32'h0000_00EC);
		@(posedge clk_sys);
		check({24'h0, pb_pin_o}, 32'h0000_00EC);
		// second reset in mid-run
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		check({pa_pin_oe, pb_pin_oe}, 16'h0000);
		bus(1'b0, OFS_A_LATCH, 32'h0, rd);
		check(rd, {24'h0, RST_A_LATCH});
		bus(1'b0, OFS_A_TYPE, 32'h0, rd);
		check(rd, {24'h0, RST_A_TYPE});
		bus(1'b0, OFS_B_DIR, 32'h0, rd);
		check(rd, {24'h0, RST_B_DIR});
		bus(1'b1, OFS_B_DIR, 32'h0000_00FF, rd);
		bus(1'b0, OFS_B_LATCH, 32'h0, rd);
		check(rd, {24'h0, RST_B_LATCH});
		give_verdict();
	end
endmodule
`default_nettype wire

// ### inc/tpio_pkg.sv
`default_nettype none
package tpio_pkg;

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int PORT_W = 8;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_A_LATCH = 8'h00;  // port_a_output_latch
	localparam logic [7:0] OFS_A_TYPE  = 8'h04;  // port_a_driver_type_ctrl
	localparam logic [7:0] OFS_A_PIN   = 8'h08;  // port_a_pin_level_read
	localparam logic [7:0] OFS_B_LATCH = 8'h0C;  // port_b_output_latch
	localparam logic [7:0] OFS_B_DIR   = 8'h10;  // port_b_direction_ctrl
	localparam logic [7:0] OFS_BITOP   = 8'h14;  // bit manipulation strobe

	// ------------------------------------------------------------
	// values after reset
	// ------------------------------------------------------------
	localparam logic [7:0] RST_A_LATCH = 8'hFF;
	localparam logic [7:0] RST_A_TYPE  = 8'h00;
	localparam logic [7:0] RST_B_LATCH = 8'h00;
	localparam logic [7:0] RST_B_DIR   = 8'h00;
	localparam logic [7:0] RST_PIN     = 8'h00;

	// ------------------------------------------------------------
	// bit manipulation word fields
	// ------------------------------------------------------------
	localparam int BITOP_IDX_LSB = 0;
	localparam int BITOP_OP_LSB  = 3;
	localparam int BITOP_PORT    = 8;

	typedef enum logic [1:0] {
		BITOP_SET = 2'h0,
		BITOP_CLR = 2'h1,
		BITOP_TGL = 2'h2,
		BITOP_NOP = 2'h3
	} tpio_bitop_e;

	// bus cycle phases, one-hot
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_S1   = 4'h2,
		ST_S2   = 4'h4,
		ST_ACK  = 4'h8
	} tpio_bus_e;

endpackage
`default_nettype wire

// ### inc/tpio_stage_if.sv
`timescale 1ns/1ns
`default_nettype none
interface tpio_stage_if #(
	parameter int W = 8
);
	logic [W-1:0] value;
	logic [W-1:0] drive_sel;
	logic [W-1:0] level;

	modport core  (output value, output drive_sel, input level);
	modport stage (input value, input drive_sel, output level);
endinterface
`default_nettype wire
